// ---- core/ddr_rx_pkg.sv ----
// Shared constants and carrier types for the dual-lane DDR data receiver
package ddr_rx_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 14;
  localparam int DELAY_W = 9;
  localparam int WINDOW_W = 4;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 9'h0A7;  // Reset code 167
  localparam logic [DELAY_W-1:0] DELAY_MAX = 9'h180;    // Code 384
  localparam logic [WINDOW_W-1:0] WINDOW_RESET = 4'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 125;
  localparam int LATENCY_CYCLES = 78;      // Capture to output
  localparam int PIPE_OVERHEAD = 4;        // Capture, write, read, out
  localparam int FIFO_PRELOAD = (LATENCY_CYCLES - PIPE_OVERHEAD) / 2;
  localparam int FIFO_DEPTH = 64;
  localparam int LOCK_TYP_CYCLES = 70000;  // Typical lock time
  localparam int LOCK_MAX_CYCLES = 135000; // Worst case lock time
  localparam int TRACK_TICK = 16;          // Cycles between adjustments
  localparam logic [1:0] QUARTER_LAST = 2'h3;
  localparam logic [1:0] HALF_PERIOD = 2'h2;
  localparam logic [1:0] QUADRATURE = 2'h1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SAMPLE_W-1:0] odd;
    logic [SAMPLE_W-1:0] even;
  } lane_pair_type;

  typedef struct packed {
    logic early;
    logic late;
  } window_type;

  typedef enum logic [2:0] {
    CTRL_IDLE = 3'b001,
    CTRL_SEARCH = 3'b010,
    CTRL_TRACK = 3'b100
  } ctrl_state_type;

endpackage

// ---- core/ddr_rx_fifo_mem.sv ----
// Elastic FIFO storage: one write port, registered read port
`timescale 1ns/100ps
`default_nettype none
module ddr_rx_fifo_mem #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 64,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_clock,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [WIDTH-1:0] o_rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage has no reset; the pointers guard against stale words
  always_ff @(posedge i_clock) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule
`default_nettype wire

// ---- core/ddr_dual_lane_data_receiver.sv ----
// Dual-lane DDR sample receiver with strobe tracking and elastic FIFO
`timescale 1ns/100ps
`default_nettype none
module ddr_dual_lane_data_receiver
  import ddr_rx_pkg::*;
#(
  parameter int W = SAMPLE_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int LOCK_HOLD = LOCK_TYP_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_input_strobe_clock,
  input wire logic [W-1:0] i_even_lane,
  input wire logic [W-1:0] i_odd_lane,
  input wire logic i_receiver_enable,
  input wire logic i_receiver_track_enable,
  input wire logic i_receiver_flag_clear,
  input wire logic i_delay_write,
  input wire logic [DELAY_W-1:0] i_strobe_delay_code,
  input wire logic [DELAY_W-1:0] i_sample_delay_code,
  input wire logic [WINDOW_W-1:0] i_window_width_code,
  output logic o_output_strobe_clock,
  output logic [W-1:0] o_sample,
  output logic o_sample_valid,
  output logic o_early_window_sample,
  output logic o_late_window_sample,
  output logic o_receiver_locked_flag,
  output logic o_lock_lost_irq,
  output logic o_fifo_error,
  output logic [DELAY_W-1:0] o_strobe_delay_code,
  output logic [DELAY_W-1:0] o_sample_delay_code
);

  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(LOCK_HOLD + 1);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The lane carrier is fixed at the full sample width
  if (W != SAMPLE_W) begin : g_bad_width
    $error("Sample width out of range");
  end
  if (DEPTH < 2 * FIFO_PRELOAD + 2) begin : g_bad_depth
    $error("FIFO too shallow for preload and skew");
  end
  if (LOCK_HOLD < 1 || LOCK_HOLD > LOCK_MAX_CYCLES) begin : g_bad_lock
    $error("Lock hold outside the lock time bound");
  end

  // ----------------------------------------------------------------
  // Quarter-rate divider and output strobe
  // ----------------------------------------------------------------
  logic [1:0] phase_r;
  logic out_strobe_r;

  // One divider phase drives the output strobe, so its relation
  // to every controller phase stays fixed
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      phase_r <= '0;
      out_strobe_r <= 1'b0;
    end else begin
      phase_r <= phase_r + 2'h1;
      out_strobe_r <= phase_r[1];
    end
  end

  // ----------------------------------------------------------------
  // Delay codes mapped to divider phases
  // ----------------------------------------------------------------
  logic [DELAY_W-1:0] strobe_del_r;
  logic [DELAY_W-1:0] sample_del_r;
  logic [1:0] strobe_phase;
  logic [1:0] early_phase;
  logic [1:0] sample_phase;
  logic codes_match;
  logic window_tick;
  logic capture_tick;

  // Top two code bits pick one of four phases of the strobe period
  assign strobe_phase = strobe_del_r[DELAY_W-1 -: 2];
  assign early_phase = strobe_phase - 2'h1;
  assign codes_match = (strobe_del_r == sample_del_r);
  // Capture sits a quarter period after the strobe edge position
  assign sample_phase = sample_del_r[DELAY_W-1 -: 2] + QUADRATURE;
  assign window_tick = (phase_r == strobe_phase);
  // Both strobe edges: capture twice per strobe period
  assign capture_tick = (phase_r[0] == sample_phase[0]);

  // ----------------------------------------------------------------
  // Early and late window samples of the strobe
  // ----------------------------------------------------------------
  logic early_r;
  logic late_r;
  logic aligned;

  // Sampling runs regardless of enable so status stays readable
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      early_r <= 1'b0;
      late_r <= 1'b0;
    end else begin
      if (phase_r == early_phase) begin
        early_r <= i_input_strobe_clock;
      end
      if (window_tick) begin
        late_r <= i_input_strobe_clock;
      end
    end
  end

  assign aligned = !early_r && late_r;

  // ----------------------------------------------------------------
  // Receiver controller: search, lock, track
  // ----------------------------------------------------------------
  ctrl_state_type state_r;
  ctrl_state_type state_nxt;
  logic [LW-1:0] hold_r;
  logic [4:0] tick_r;
  logic run;
  logic adjust;
  logic [DELAY_W-1:0] step;
  logic [DELAY_W-1:0] del_up;
  logic [DELAY_W-1:0] del_dn;
  logic locked_r;
  logic irq_r;
  logic lock_lost;

  assign run = i_receiver_enable && i_receiver_track_enable;
  assign adjust = run && (tick_r == 5'(TRACK_TICK - 1)) && !aligned;
  // Wider window moves the delay in bigger steps: faster loop
  assign step = DELAY_W'(i_window_width_code) + 9'h001;
  assign del_up = (strobe_del_r > DELAY_MAX - step) ? DELAY_MAX
                                                   : strobe_del_r + step;
  assign del_dn = (strobe_del_r < step) ? '0 : strobe_del_r - step;
  assign lock_lost = locked_r && run && !aligned;

  // Next state of the controller
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CTRL_IDLE: begin
        if (run) begin
          state_nxt = CTRL_SEARCH;
        end
      end
      CTRL_SEARCH: begin
        if (!run) begin
          state_nxt = CTRL_IDLE;
        end else if (hold_r == LW'(LOCK_HOLD - 1)) begin
          state_nxt = CTRL_TRACK;
        end
      end
      CTRL_TRACK: begin
        if (!run) begin
          state_nxt = CTRL_IDLE;
        end else if (lock_lost) begin
          state_nxt = CTRL_SEARCH;
        end
      end
      default: state_nxt = CTRL_IDLE;
    endcase
  end

  // Search counts aligned cycles; any miss restarts the count
  always_ff @(posedge i_clock) begin
    if (i_srst || state_r != CTRL_SEARCH || !aligned) begin
      hold_r <= '0;
    end else begin
      hold_r <= hold_r + LW'(1);
    end
  end

  // Adjustment pacing shared by search and track
  always_ff @(posedge i_clock) begin
    if (i_srst || !run) begin
      tick_r <= '0;
    end else if (tick_r == 5'(TRACK_TICK - 1)) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick_r + 5'h01;
    end
  end

  // Delay codes: software writes while idle, loop moves both together
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_r <= CTRL_IDLE;
      strobe_del_r <= DELAY_RESET;
      sample_del_r <= DELAY_RESET;
    end else begin
      state_r <= state_nxt;
      if (!run && i_delay_write) begin
        strobe_del_r <= i_strobe_delay_code;
        sample_del_r <= i_sample_delay_code;
      end else if (adjust) begin
        // Strobe seen high early: edge came sooner, pull delay down
        strobe_del_r <= early_r ? del_dn : del_up;
        sample_del_r <= early_r ? del_dn : del_up;
      end
    end
  end

  // Lock flag and sticky lock-loss interrupt; a loss beats a clear
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      locked_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      locked_r <= (state_nxt == CTRL_TRACK);
      if (lock_lost) begin
        irq_r <= 1'b1;
      end else if (i_receiver_flag_clear) begin
        irq_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // First-stage capture and elastic FIFO write side
  // ----------------------------------------------------------------
  lane_pair_type cap_r;
  lane_pair_type rd_pair;
  logic cap_valid_r;
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic [AW:0] fill;
  logic fifo_full;
  logic fifo_empty;
  logic rd_en;
  logic err_r;

  assign fill = wr_ptr_r - rd_ptr_r;
  assign fifo_full = (fill == (AW+1)'(DEPTH));
  assign fifo_empty = (fill == '0);

  // Each capture holds one even and one odd word, offset binary kept
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cap_r <= '0;
      cap_valid_r <= 1'b0;
    end else begin
      cap_valid_r <= capture_tick && codes_match;
      if (capture_tick) begin
        cap_r.even <= i_even_lane;
        cap_r.odd <= i_odd_lane;
      end
    end
  end

  // Pointers; an overrun or underrun is latched until reset
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      wr_ptr_r <= '0;
      err_r <= 1'b0;
    end else begin
      if (cap_valid_r && !fifo_full) begin
        wr_ptr_r <= wr_ptr_r + (AW+1)'(1);
      end
      if ((cap_valid_r && fifo_full) || (rd_en && fifo_empty)) begin
        err_r <= 1'b1;
      end
    end
  end

  ddr_rx_fifo_mem #(
    .WIDTH(2 * W),
    .DEPTH(DEPTH)
  ) u_fifo_mem (
    .i_clock(i_clock),
    .i_wr_en(cap_valid_r && !fifo_full),
    .i_wr_addr(wr_ptr_r[AW-1:0]),
    .i_wr_data(cap_r),
    .i_rd_en(rd_en && !fifo_empty),
    .i_rd_addr(rd_ptr_r[AW-1:0]),
    .o_rd_data(rd_pair)
  );

  // ----------------------------------------------------------------
  // Read side and even/odd reassembly
  // ----------------------------------------------------------------
  logic primed_r;
  logic half_r;
  logic rd_valid_r;
  logic [W-1:0] sample_r;
  logic sample_valid_r;
  logic odd_next_r;

  // Preload sets the latency; reading then drains one pair per two
  assign rd_en = primed_r && !half_r;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rd_ptr_r <= '0;
      primed_r <= 1'b0;
      half_r <= 1'b0;
      rd_valid_r <= 1'b0;
    end else begin
      if (fill >= (AW+1)'(FIFO_PRELOAD)) begin
        primed_r <= 1'b1;
      end
      half_r <= primed_r && !half_r;
      rd_valid_r <= rd_en && !fifo_empty;
      if (rd_en && !fifo_empty) begin
        rd_ptr_r <= rd_ptr_r + (AW+1)'(1);
      end
    end
  end

  // Even word first, odd word next cycle: full rate, original order
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sample_r <= '0;
      sample_valid_r <= 1'b0;
      odd_next_r <= 1'b0;
    end else begin
      // The odd word of a pair follows its even word by one cycle
      odd_next_r <= rd_valid_r;
      sample_valid_r <= rd_valid_r || odd_next_r;
      sample_r <= rd_valid_r ? rd_pair.even : rd_pair.odd;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_output_strobe_clock <= 1'b0;
      o_sample <= '0;
      o_sample_valid <= 1'b0;
      o_early_window_sample <= 1'b0;
      o_late_window_sample <= 1'b0;
      o_receiver_locked_flag <= 1'b0;
      o_lock_lost_irq <= 1'b0;
      o_fifo_error <= 1'b0;
      o_strobe_delay_code <= DELAY_RESET;
      o_sample_delay_code <= DELAY_RESET;
    end else begin
      o_output_strobe_clock <= out_strobe_r;
      o_sample <= sample_r;
      o_sample_valid <= sample_valid_r;
      o_early_window_sample <= early_r;
      o_late_window_sample <= late_r;
      o_receiver_locked_flag <= locked_r;
      o_lock_lost_irq <= irq_r;
      o_fifo_error <= err_r;
      o_strobe_delay_code <= strobe_del_r;
      o_sample_delay_code <= sample_del_r;
    end
  end

endmodule
`default_nettype wire

// ---- verif/ddr_rx_sva.sv ----
// Port assertions for the dual-lane DDR data receiver
`timescale 1ns/100ps
`default_nettype none
module ddr_rx_sva
  import ddr_rx_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_receiver_enable,
  input wire logic i_receiver_track_enable,
  input wire logic i_receiver_flag_clear,
  input wire logic o_output_strobe_clock,
  input wire logic o_sample_valid,
  input wire logic o_early_window_sample,
  input wire logic o_late_window_sample,
  input wire logic o_receiver_locked_flag,
  input wire logic o_lock_lost_irq,
  input wire logic o_fifo_error,
  input wire logic [DELAY_W-1:0] o_strobe_delay_code,
  input wire logic [DELAY_W-1:0] o_sample_delay_code
);
  // ------------
  // Helpers
  // ------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  // Loop runs only with both control bits; lock rides on this
  wire run = i_receiver_enable && i_receiver_track_enable;
  wire aligned = !o_early_window_sample && o_late_window_sample;
  // Rest of one strobe period after a rise: one high, two low, high
  sequence strobe_rest;
    o_output_strobe_clock ##1 !o_output_strobe_clock [*2]
      ##1 o_output_strobe_clock;
  endsequence
  // Run held long enough that a lock drop cannot come from disabling
  sequence run_held;
    run [*4];
  endsequence
  a_reset_values: assert property (
    $past(i_srst) |-> !o_sample_valid && !o_receiver_locked_flag
      && !o_lock_lost_irq && !o_fifo_error
      && o_strobe_delay_code == DELAY_RESET)
    else $error("outputs off reset values");
  a_strobe_quarter: assert property (
    $rose(o_output_strobe_clock) |=> strobe_rest)
    else $error("output strobe not at quarter rate");
  a_code_ceiling: assert property (
    o_strobe_delay_code <= DELAY_MAX && o_sample_delay_code <= DELAY_MAX)
    else $error("delay code above range");
  a_locked_codes_match: assert property (
    o_receiver_locked_flag |-> o_strobe_delay_code == o_sample_delay_code)
    else $error("locked with unequal codes");
  a_lock_needs_run: assert property (
    !run [*3] |=> !o_receiver_locked_flag)
    else $error("locked while loop off");
  a_lock_when_aligned: assert property (
    $rose(o_receiver_locked_flag) |-> aligned)
    else $error("lock while misaligned");
  a_irq_sticky: assert property (
    o_lock_lost_irq && !i_receiver_flag_clear
      && !$past(i_receiver_flag_clear) |=> o_lock_lost_irq)
    else $error("lock-lost flag dropped");
  a_loss_raises_irq: assert property (
    run_held ##0 $fell(o_receiver_locked_flag) |-> ##[0:2] o_lock_lost_irq)
    else $error("lock lost without flag");
  a_fifo_err_sticky: assert property (
    o_fifo_error |=> o_fifo_error)
    else $error("fifo error dropped");
endmodule
bind ddr_dual_lane_data_receiver ddr_rx_sva u_ddr_rx_sva (
  .i_clock, .i_srst, .i_receiver_enable, .i_receiver_track_enable,
  .i_receiver_flag_clear, .o_output_strobe_clock, .o_sample_valid,
  .o_early_window_sample, .o_late_window_sample, .o_receiver_locked_flag,
  .o_lock_lost_irq, .o_fifo_error, .o_strobe_delay_code,
  .o_sample_delay_code
);
`default_nettype wire

// ---- verif/host_lane_model.sv ----
// Host lane driver model: strobe plus even and odd sample lanes
`timescale 1ns/100ps
`default_nettype none
module host_lane_model
  import ddr_rx_pkg::*;
#(
  parameter logic [SAMPLE_W-1:0] BASE = 14'h0
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [1:0] i_skew,
  output logic o_input_strobe_clock,
  output logic [SAMPLE_W-1:0] o_even_lane,
  output logic [SAMPLE_W-1:0] o_odd_lane
);
  logic [15:0] tick_r = 16'h0;
  logic [15:0] pos;
  logic [SAMPLE_W-1:0] pair_idx;
  // Host launches off the falling edge so words settle before capture
  always @(negedge i_clock) begin
    tick_r <= i_srst ? 16'h0 : tick_r + 16'h1;
  end
  // Skew moves strobe and words together, as one host output path
  assign pos = tick_r + {14'h0, i_skew};
  assign pair_idx = pos[SAMPLE_W:1];
  // Strobe is an extra lane toggling on every word change
  assign o_input_strobe_clock = pos[1];
  // Even indices on one lane, odd on the other, offset binary count
  assign o_even_lane = BASE + {pair_idx[SAMPLE_W-2:0], 1'b0};
  assign o_odd_lane = BASE + {pair_idx[SAMPLE_W-2:0], 1'b1};
endmodule
`default_nettype wire

// ---- verif/tb_ddr_dual_lane_data_receiver.sv ----
// Self-checking bench for the dual-lane DDR data receiver
`timescale 1ns/100ps
`default_nettype none
module tb_ddr_dual_lane_data_receiver
  import ddr_rx_pkg::*;
;
  localparam int HOLD = 50;
  localparam int WAIT_LOCK = 6000;
  localparam logic [SAMPLE_W-1:0] BASE = 14'h3FF0;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic i_receiver_enable = 1'b0;
  logic i_receiver_track_enable = 1'b0;
  logic i_receiver_flag_clear = 1'b0;
  logic i_delay_write = 1'b0;
  logic [DELAY_W-1:0] i_strobe_delay_code = DELAY_RESET;
  logic [DELAY_W-1:0] i_sample_delay_code = DELAY_RESET;
  logic [WINDOW_W-1:0] i_window_width_code = 4'h2; // Start-up width
  logic [1:0] skew = 2'h0;
  logic i_input_strobe_clock;
  logic [SAMPLE_W-1:0] i_even_lane, i_odd_lane, o_sample;
  logic o_output_strobe_clock, o_sample_valid, o_early_window_sample;
  logic o_late_window_sample, o_receiver_locked_flag, o_lock_lost_irq;
  logic o_fifo_error;
  logic [DELAY_W-1:0] o_strobe_delay_code, o_sample_delay_code;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;

  // Lock hold shortened so a search fits in a few thousand cycles
  ddr_dual_lane_data_receiver #(
    .LOCK_HOLD(HOLD)
  ) u_ddr_dual_lane_data_receiver (
    .i_clock, .i_srst, .i_input_strobe_clock, .i_even_lane, .i_odd_lane,
    .i_receiver_enable, .i_receiver_track_enable, .i_receiver_flag_clear,
    .i_delay_write, .i_strobe_delay_code, .i_sample_delay_code,
    .i_window_width_code, .o_output_strobe_clock, .o_sample,
    .o_sample_valid, .o_early_window_sample, .o_late_window_sample,
    .o_receiver_locked_flag, .o_lock_lost_irq, .o_fifo_error,
    .o_strobe_delay_code, .o_sample_delay_code
  );
  host_lane_model #(
    .BASE(BASE)
  ) u_host_lane_model (
    .i_clock, .i_srst, .i_skew(skew),
    .o_input_strobe_clock(i_input_strobe_clock),
    .o_even_lane(i_even_lane),
    .o_odd_lane(i_odd_lane)
  );

  // ------------
  // Clock, cycle count, watchdog
  // ------------
  initial begin
    forever #4 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc <= i_srst ? 0 : cyc + 1;
  end
  // Normal run is under 15k cycles; triple that means a hang
  initial begin
    #(8 * 45000);
    n_errors++;
    report_and_stop();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic report_and_stop();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    i_srst <= 1'b1;
    idle(20);
    i_srst <= 1'b0;
    idle(1);
  endtask
  task automatic load_codes(input logic [DELAY_W-1:0] s,
                            input logic [DELAY_W-1:0] p);
    i_strobe_delay_code <= s;
    i_sample_delay_code <= p;
    i_delay_write <= 1'b1;
    idle(1);
    i_delay_write <= 1'b0;
    idle(2);
  endtask

  // Loop off: exactly one of four strobe phases reads as aligned
  task automatic t_window_live();
    int hits = 0;
    for (int s = 0; s < 4; s++) begin
      skew <= 2'(s);
      idle(12);
      if ({o_early_window_sample, o_late_window_sample} === 2'b01) hits++;
    end
    chk(hits, 1);
    skew <= 2'h0;
  endtask
  // Stream in order, unbroken, with capture-to-output near 78 cycles
  task automatic t_stream();
    logic [SAMPLE_W-1:0] idx, nxt;
    int lat;
    int got = 0;
    int n = 0;
    while (o_sample_valid !== 1'b1 && n < 200) begin
      idle(1);
      n++;
    end
    repeat (64) begin
      if (o_sample_valid === 1'b1) begin
        idx = o_sample - BASE;
        lat = cyc - int'(idx);
        if (got == 0) chk(idx[0], 1'b0);
        else chk(o_sample, nxt);
        // Three cycles either side allowed for the strobe-to-capture offset
        chk(lat >= LATENCY_CYCLES - 3 && lat <= LATENCY_CYCLES + 3, 1);
        nxt = o_sample + 1'b1;
        got++;
      end
      idle(1);
    end
    chk(got, 64);
    chk(o_fifo_error, 0);
  endtask
  // Top code loads; unequal codes starve the FIFO into an error
  task automatic t_codes();
    int n = 0;
    load_codes(DELAY_MAX, DELAY_MAX);
    chk(o_strobe_delay_code, DELAY_MAX);
    chk(o_sample_delay_code, DELAY_MAX);
    load_codes(DELAY_RESET, 9'h064);
    chk(o_sample_delay_code, 9'h064);
    while (o_fifo_error !== 1'b1 && n < 200) begin
      idle(1);
      n++;
    end
    chk(o_fifo_error, 1);
  endtask
  // Enable in two writes, watch the step size, then wait for lock
  task automatic t_lock();
    logic [DELAY_W-1:0] d;
    logic seen = 1'b0;
    int n = 0;
    i_receiver_enable <= 1'b0;
    i_receiver_track_enable <= 1'b0;
    idle(4);
    i_receiver_track_enable <= 1'b1;
    idle(4);
    i_receiver_enable <= 1'b1;
    while (o_receiver_locked_flag !== 1'b1 && n < WAIT_LOCK) begin
      if (!seen && o_strobe_delay_code !== DELAY_RESET) begin
        seen = 1'b1;
        d = o_strobe_delay_code - DELAY_RESET;
        if (d[DELAY_W-1]) d = -d;
        chk(d, i_window_width_code + 1'b1);
      end
      idle(1);
      n++;
    end
    chk(o_receiver_locked_flag, 1);
    chk({o_early_window_sample, o_late_window_sample}, 2'b01);
  endtask
  // Half-period jump breaks lock; flag clears; loop relocks on its own
  task automatic t_loss();
    int n = 0;
    skew <= 2'h2;
    while (o_lock_lost_irq !== 1'b1 && n < 300) begin
      idle(1);
      n++;
    end
    chk(o_lock_lost_irq, 1);
    chk(o_receiver_locked_flag, 0);
    i_receiver_flag_clear <= 1'b1;
    idle(1);
    i_receiver_flag_clear <= 1'b0;
    idle(2);
    chk(o_lock_lost_irq, 0);
    n = 0;
    while (o_receiver_locked_flag !== 1'b1 && n < WAIT_LOCK) begin
      idle(1);
      n++;
    end
    chk(o_receiver_locked_flag, 1);
  endtask

  initial begin
    do_reset();
    t_window_live();
    do_reset();
    t_stream();
    t_codes();
    do_reset();
    t_lock();
    t_loss();
    report_and_stop();
  end
endmodule
`default_nettype wire
